// [include/ues_pkg.sv]
// Constants, types and the state record of the USB endpoint status block.
package ues_pkg;
  // ****************************************
  // Register indices, byte address = 4 x index
  // ****************************************
  localparam logic [5:0] IDX_ISTAT = 6'h20;
  localparam logic [5:0] IDX_IMASK = 6'h21;
  localparam logic [5:0] IDX_CTRL = 6'h22;
  localparam logic [5:0] IDX_DEVICE_ADDRESS = 6'h23;
  localparam logic [5:0] IDX_LASTSR = 6'h24;
  localparam logic [5:0] IDX_EP0 = 6'h25;
  localparam logic [5:0] IDX_CNT0RX = 6'h26;
  localparam logic [5:0] IDX_CNT0TX = 6'h27;
  localparam logic [5:0] IDX_EP1TX = 6'h28;
  localparam logic [5:0] IDX_CNT1TX = 6'h29;
  localparam logic [5:0] IDX_EP2RX = 6'h2A;
  localparam logic [5:0] IDX_CNT2RX = 6'h2B;
  localparam logic [5:0] IDX_FAULT = 6'h2C;
  localparam logic [5:0] IDX_CNT2TX = 6'h2D;
  // ****************************************
  // Field positions and writable masks
  // ****************************************
  localparam int IST_CTR = 7;
  localparam int IST_ERR = 4;
  localparam int IST_RESET = 1;
  localparam int IST_SOF = 0;
  localparam int CTL_FORCE_BUS_RESET = 0;
  localparam int EPZ_CTR = 7;
  localparam int EPZ_TXTOG = 6;
  localparam int EPZ_TXST = 4;
  localparam int EPZ_RXTOG = 2;
  localparam int EPZ_RXST = 0;
  localparam int EPN_CTR = 3;
  localparam int EPN_TOG = 2;
  localparam int EPN_ST = 0;
  localparam logic [7:0] WM_EP0 = 8'hF7;
  localparam logic [7:0] WM_EPN = 8'h0F;
  localparam logic [7:0] WM_CNT4 = 8'h0F;
  localparam logic [7:0] WM_CNT7 = 8'h7F;
  localparam logic [7:0] WM_CTRL = 8'hCF;
  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] RST_CTRL = 8'h06;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] ST_DIS = 2'h0;
  localparam logic [1:0] ST_STALL = 2'h1;
  localparam logic [1:0] ST_NAK = 2'h2;
  localparam logic [1:0] ST_VALID = 2'h3;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_STUFF = 3'h1;
  localparam logic [2:0] ERR_CRC = 3'h2;
  localparam logic [2:0] ERR_EOP = 3'h3;
  localparam logic [2:0] ERR_PID = 3'h4;
  localparam logic [2:0] ERR_MEM = 3'h5;
  localparam logic [2:0] ERR_OTHER = 3'h7;
  typedef enum logic [1:0] {
    XK_OUT = 2'b00,
    XK_IN = 2'b01,
    XK_SETUP = 2'b10
  } ues_kind_e;
  typedef enum logic [1:0] {
    HS_NONE = 2'b00,
    HS_STALL = 2'b01,
    HS_NAK = 2'b10,
    HS_ACK = 2'b11
  } ues_hs_e;
  typedef struct packed {
    logic token;
    logic xact;
    logic [1:0] ep;
    ues_kind_e kind;
    logic ok;
    logic ack;
    logic stall;
    logic [2:0] err;
    logic [6:0] rx_bytes;
    logic bus_reset;
    logic sof;
  } ues_evt_s;
  typedef struct packed {
    logic [7:0] ep0;
    logic [7:0] ep1tx;
    logic [7:0] ep2rx;
    logic [7:0] device_address;
  } ues_view_s;
  typedef struct packed {
    logic [7:0] istat;
    logic [7:0] imask;
    logic [7:0] ctrl;
    logic [7:0] device_address;
    logic [7:0] lastsr;
    logic [7:0] ep0;
    logic [7:0] cnt0rx;
    logic [7:0] cnt0tx;
    logic [7:0] ep1tx;
    logic [7:0] cnt1tx;
    logic [7:0] ep2rx;
    logic [7:0] cnt2rx;
    logic [7:0] fault;
    logic [7:0] cnt2tx;
    logic ack;
    logic [31:0] rdata;
    logic irq;
    ues_hs_e hs;
    logic hs_vld;
    logic [6:0] in_len;
  } ues_state_s;
endpackage

// [design/ues_top.sv]
// USB endpoint status, toggle, counter and error reporting registers.
// Operation
// - The last error is kept as a 3-bit code: 0 none, 1 stuffing, 2 CRC, 3 EOP, 4 PID, 5 memory, 7 other.
// - The error code loads with the error interrupt and clears when the error pending flag is cleared.
// - The upper five bits of the fault register always read zero.
// - A bus or forced USB reset clears toggle and status bits of both directions of endpoint 0.
// - A bus or forced USB reset clears toggle and status bits of every transmit endpoint.
// - Endpoint 0 gets its transfer-done flag set on success, and software clears it.
// - Receive status NAK answers every reception except a SETUP to endpoint 0 with NAK, and VALID handles the transaction.
// - A correct transfer forces every status field of that endpoint to NAK.
// - A SETUP on an enabled endpoint is acknowledged and both status fields go to NAK.
// - Answering STALL sets every status field of that endpoint to STALL.
// - A transmit endpoint gets its transfer-done flag on success, bits 7 to 4 read zero.
// - The transmit toggle picks DATA0 or DATA1 and flips only after the host ACK.
// - Toggles update in hardware on a relevant PID and accept software writes.
// - After a reception the receive count holds the allocated size minus received bytes.
// - An IN token to endpoint 2 sends exactly the 7-bit transmit count of endpoint 2.
`timescale 1ns/100ps
`default_nettype none
module ues_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire ues_pkg::ues_evt_s evt_i,
  output ues_pkg::ues_view_s view_o,
  output ues_pkg::ues_hs_e hs_o,
  output logic hs_vld_o,
  output logic [6:0] in_len_o,
  output logic irq_o
);
  import ues_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // Handshake that a status field gives to a token.
  function automatic ues_hs_e answer(input logic [1:0] st);
    ues_hs_e a;
    unique case (st)
      ST_DIS: a = HS_NONE;
      ST_STALL: a = HS_STALL;
      ST_NAK: a = HS_NAK;
      ST_VALID: a = HS_ACK;
    endcase
    return a;
  endfunction

  function automatic logic [7:0] rd_reg(input ues_state_s r,
                                        input logic [5:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_ISTAT: v = r.istat;
      IDX_IMASK: v = r.imask;
      IDX_CTRL: v = r.ctrl;
      IDX_DEVICE_ADDRESS: v = r.device_address;
      IDX_LASTSR: v = r.lastsr;
      IDX_EP0: v = r.ep0;
      IDX_CNT0RX: v = r.cnt0rx;
      IDX_CNT0TX: v = r.cnt0tx;
      IDX_EP1TX: v = r.ep1tx;
      IDX_CNT1TX: v = r.cnt1tx;
      IDX_EP2RX: v = r.ep2rx;
      IDX_CNT2RX: v = r.cnt2rx;
      IDX_FAULT: v = {5'h00, r.fault[2:0]};
      IDX_CNT2TX: v = r.cnt2tx;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ues_state_s s;
  ues_state_s next_s;
  logic hit;
  logic force_bus_reset;
  logic good;
  logic [5:0] idx;
  logic [7:0] wd;

  assign idx = adr_i[7:2];
  assign wd = dat_i[7:0];
  assign hit = cyc_i & stb_i & ~s.ack;
  assign force_bus_reset = evt_i.bus_reset | s.ctrl[CTL_FORCE_BUS_RESET];
  assign good = evt_i.ok & ~evt_i.stall
                & ((evt_i.kind != XK_IN) | evt_i.ack);

  // ****************************************
  // Next state
  // ****************************************
  // Bus writes are applied first and hardware events after them, so an
  // event in the cycle of a clear always survives.
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.hs_vld = 1'b0;
    if (hit) begin
      next_s.ack = 1'b1;
      next_s.rdata = {24'h000000, rd_reg(s, idx)};
      if (we_i && sel_i[0]) begin
        case (idx)
          IDX_IMASK: next_s.imask = wd;
          IDX_CTRL: next_s.ctrl = wd & WM_CTRL;
          IDX_DEVICE_ADDRESS: next_s.device_address = wd & WM_CNT7;
          IDX_EP0: next_s.ep0 = wd & WM_EP0;
          IDX_CNT0RX: next_s.cnt0rx = wd & WM_CNT4;
          IDX_CNT0TX: next_s.cnt0tx = wd & WM_CNT4;
          IDX_EP1TX: next_s.ep1tx = wd & WM_EPN;
          IDX_CNT1TX: next_s.cnt1tx = wd & WM_CNT4;
          IDX_EP2RX: next_s.ep2rx = wd & WM_EPN;
          IDX_CNT2RX: next_s.cnt2rx = wd & WM_CNT7;
          IDX_CNT2TX: next_s.cnt2tx = wd & WM_CNT7;
          default: ;
        endcase
      end
      // Reading the status register clears it.
      if (!we_i && idx == IDX_ISTAT) begin
        next_s.istat = RST_ZERO;
      end
    end
    if (!next_s.istat[IST_ERR]) begin
      next_s.fault = RST_ZERO;
    end
    if (force_bus_reset) begin
      next_s.ep0[6:4] = 3'h0;
      next_s.ep0[2:0] = 3'h0;
      next_s.ep1tx[2:0] = 3'h0;
      next_s.ep2rx[2:0] = 3'h0;
      next_s.istat[IST_RESET] = 1'b1;
    end else if (evt_i.xact) begin
      if (evt_i.stall) begin
        unique case (evt_i.ep)
          2'd0: begin
            next_s.ep0[EPZ_TXST+:2] = ST_STALL;
            next_s.ep0[EPZ_RXST+:2] = ST_STALL;
          end
          2'd1: next_s.ep1tx[EPN_ST+:2] = ST_STALL;
          default: next_s.ep2rx[EPN_ST+:2] = ST_STALL;
        endcase
      end else if (good) begin
        next_s.istat[IST_CTR] = 1'b1;
        next_s.lastsr = {evt_i.kind, evt_i.kind == XK_IN, 3'h0,
                         evt_i.ep};
        unique case (evt_i.ep)
          2'd0: begin
            // A SETUP to a disabled endpoint is not acknowledged.
            if (evt_i.kind != XK_SETUP
                || s.ep0[EPZ_RXST+:2] != ST_DIS) begin
              next_s.ep0[EPZ_CTR] = 1'b1;
              next_s.ep0[EPZ_TXST+:2] = ST_NAK;
              next_s.ep0[EPZ_RXST+:2] = ST_NAK;
              unique case (evt_i.kind)
                XK_IN: next_s.ep0[EPZ_TXTOG] = ~s.ep0[EPZ_TXTOG];
                XK_OUT: next_s.ep0[EPZ_RXTOG] = ~s.ep0[EPZ_RXTOG];
                default: begin
                  // A SETUP is always DATA0, so both sides continue DATA1.
                  next_s.ep0[EPZ_TXTOG] = 1'b1;
                  next_s.ep0[EPZ_RXTOG] = 1'b1;
                end
              endcase
              if (evt_i.kind != XK_IN) begin
                next_s.cnt0rx = {4'h0, s.cnt0rx[3:0]
                                 - evt_i.rx_bytes[3:0]};
              end
            end
          end
          2'd1: begin
            next_s.ep1tx[EPN_CTR] = 1'b1;
            next_s.ep1tx[EPN_ST+:2] = ST_NAK;
            next_s.ep1tx[EPN_TOG] = ~s.ep1tx[EPN_TOG];
          end
          default: begin
            next_s.ep2rx[EPN_CTR] = 1'b1;
            next_s.ep2rx[EPN_ST+:2] = ST_NAK;
            next_s.ep2rx[EPN_TOG] = ~s.ep2rx[EPN_TOG];
            next_s.cnt2rx = {1'b0, s.cnt2rx[6:0]
                             - evt_i.rx_bytes};
          end
        endcase
      end else begin
        next_s.istat[IST_ERR] = 1'b1;
        next_s.fault = {5'h00, evt_i.err};
      end
    end
    if (evt_i.sof) begin
      next_s.istat[IST_SOF] = 1'b1;
    end
    if (evt_i.token) begin
      next_s.hs_vld = 1'b1;
      unique case (evt_i.ep)
        2'd0: begin
          if (evt_i.kind == XK_SETUP) begin
            // A SETUP is acknowledged whenever the endpoint is enabled,
            // even while it is NAKed or stalled for data.
            next_s.hs = (s.ep0[EPZ_RXST+:2] == ST_DIS)
                        ? HS_NONE : HS_ACK;
          end else if (evt_i.kind == XK_IN) begin
            next_s.hs = answer(s.ep0[EPZ_TXST+:2]);
          end else begin
            next_s.hs = answer(s.ep0[EPZ_RXST+:2]);
          end
        end
        2'd1: next_s.hs = answer(s.ep1tx[EPN_ST+:2]);
        default: next_s.hs = answer(s.ep2rx[EPN_ST+:2]);
      endcase
      if (evt_i.ep == 2'd2 && evt_i.kind == XK_IN) begin
        next_s.in_len = s.cnt2tx[6:0];
      end
    end
    next_s.irq = |(next_s.istat & next_s.imask);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.ctrl <= RST_CTRL;
      s.hs <= HS_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign dat_o = s.rdata;
  assign ack_o = s.ack;
  assign irq_o = s.irq;
  assign hs_o = s.hs;
  assign hs_vld_o = s.hs_vld;
  assign in_len_o = s.in_len;
  assign view_o = '{ep0: s.ep0, ep1tx: s.ep1tx, ep2rx: s.ep2rx,
                    device_address: s.device_address};

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_fault_upper_zero: assert property (s.fault[7:3] == 5'h00)
    else $error("fault upper bits not zero");
  a_fault_load: assert property (evt_i.xact && !force_bus_reset && !good
      && !evt_i.stall |=> s.istat[IST_ERR]
      && s.fault[2:0] == $past(evt_i.err))
    else $error("fault code not loaded");
  a_fault_clear: assert property ($fell(s.istat[IST_ERR])
      |-> s.fault == 8'h00)
    else $error("fault code kept after flag cleared");
  a_reset_ep_zero: assert property (force_bus_reset
      |=> s.ep0[6:4] == 3'h0 && s.ep0[2:0] == 3'h0)
    else $error("endpoint 0 not cleared by reset");
  a_reset_tx_ep: assert property (force_bus_reset |=> s.ep1tx[2:0] == 3'h0)
    else $error("transmit endpoint not cleared by reset");
  a_ctr_sets_nak: assert property (evt_i.xact && !force_bus_reset && good
      && evt_i.ep == 2'd0 && evt_i.kind == XK_OUT
      |=> s.ep0[EPZ_CTR] && s.ep0[5:4] == ST_NAK
      && s.ep0[1:0] == ST_NAK)
    else $error("endpoint 0 not NAKed after transfer");
  a_stall_both: assert property (evt_i.xact && !force_bus_reset && evt_i.stall
      && evt_i.ep == 2'd0
      |=> s.ep0[5:4] == ST_STALL && s.ep0[1:0] == ST_STALL)
    else $error("stall not set on both directions");
  a_tx_toggle_ack: assert property (evt_i.xact && !force_bus_reset
      && evt_i.ep == 2'd1 && !good
      |=> s.ep1tx[EPN_TOG] == $past(s.ep1tx[EPN_TOG])
      || $past(hit && we_i))
    else $error("transmit toggle moved without ACK");
  a_tx_upper_zero: assert property (s.ep1tx[7:4] == 4'h0)
    else $error("transmit register upper bits not zero");
  a_rx_count: assert property (evt_i.xact && !force_bus_reset && good
      && evt_i.ep == 2'd2
      |=> s.cnt2rx[6:0] == $past(s.cnt2rx[6:0] - evt_i.rx_bytes))
    else $error("receive count wrong");
  a_in_length: assert property (evt_i.token && evt_i.ep == 2'd2
      && evt_i.kind == XK_IN
      |=> hs_vld_o && in_len_o == $past(s.cnt2tx[6:0]))
    else $error("IN length not taken from count");
  a_nak_answer: assert property (evt_i.token && evt_i.ep == 2'd2
      && s.ep2rx[1:0] == ST_NAK |=> hs_o == HS_NAK)
    else $error("NAK status not answered with NAK");
  a_bus_ack: assert property (hit |=> ack_o ##1 !ack_o)
    else $error("bus answer not one cycle");
  a_setup_ack: assert property (evt_i.token && evt_i.ep == 2'd0
      && evt_i.kind == XK_SETUP && s.ep0[1:0] != ST_DIS
      |=> hs_o == HS_ACK)
    else $error("SETUP not acknowledged");
  a_setup_nak: assert property (evt_i.xact && !force_bus_reset && good
      && evt_i.ep == 2'd0 && evt_i.kind == XK_SETUP
      && s.ep0[1:0] != ST_DIS
      |=> s.ep0[5:4] == ST_NAK && s.ep0[1:0] == ST_NAK)
    else $error("SETUP did not NAK both directions");
  a_setup_drop: assert property (evt_i.xact && !force_bus_reset && good
      && evt_i.ep == 2'd0 && evt_i.kind == XK_SETUP
      && s.ep0[1:0] == ST_DIS
      |=> s.ep0 == $past(s.ep0) || $past(hit && we_i))
    else $error("SETUP to disabled endpoint changed it");
  a_ep_zero_ctr: assert property (evt_i.xact && !force_bus_reset && good
      && evt_i.ep == 2'd0 && evt_i.kind != XK_SETUP
      |=> s.ep0[EPZ_CTR])
    else $error("endpoint 0 transfer flag not set");
  a_tx_ctr_set: assert property (evt_i.xact && !force_bus_reset && good
      && evt_i.ep == 2'd1
      |=> s.ep1tx[EPN_CTR] && s.ep1tx[1:0] == ST_NAK)
    else $error("transmit transfer flag not set");
  a_tx_toggle_flip: assert property (evt_i.xact && !force_bus_reset && good
      && evt_i.ep == 2'd1
      |=> s.ep1tx[EPN_TOG] != $past(s.ep1tx[EPN_TOG]))
    else $error("transmit toggle not flipped after ACK");
  a_rx_toggle_flip: assert property (evt_i.xact && !force_bus_reset && good
      && evt_i.ep == 2'd2
      |=> s.ep2rx[EPN_TOG] != $past(s.ep2rx[EPN_TOG]))
    else $error("receive toggle not flipped");
  a_stall_tx_ep: assert property (evt_i.xact && !force_bus_reset && evt_i.stall
      && evt_i.ep == 2'd1 |=> s.ep1tx[1:0] == ST_STALL)
    else $error("transmit endpoint not stalled");
  a_tx_nak_answer: assert property (evt_i.token && evt_i.ep == 2'd1
      && s.ep1tx[1:0] == ST_NAK |=> hs_o == HS_NAK)
    else $error("transmit NAK status not answered with NAK");
  a_valid_answer: assert property (evt_i.token && evt_i.ep == 2'd2
      && s.ep2rx[1:0] == ST_VALID |=> hs_o == HS_ACK)
    else $error("valid status not answered with ACK");
  a_reset_flag: assert property (force_bus_reset |=> s.istat[IST_RESET])
    else $error("reset flag not raised");
  a_irq_level: assert property (irq_o == |(s.istat & s.imask))
    else $error("interrupt level wrong");

  c_ep0_done: cover property (evt_i.xact && good && evt_i.ep == 2'd0);
  c_stall: cover property (evt_i.xact && evt_i.stall);
  c_error: cover property (evt_i.xact && !good && !evt_i.stall);
  c_reset: cover property (force_bus_reset ##1 irq_o);
  c_setup_ack: cover property (evt_i.token && evt_i.ep == 2'd0
      && evt_i.kind == XK_SETUP);
endmodule
`default_nettype wire

// [test/ues_host_model.sv]
// Host side model that hands decoded bus events to the endpoint block.
`timescale 1ns/100ps
`default_nettype none
module ues_host_model (
  input wire logic clk_i,
  output ues_pkg::ues_evt_s evt_o
);
  import ues_pkg::*;
  // ****************************************
  // Event driver
  // ****************************************
  initial begin
    evt_o = '0;
  end
  // Events last one cycle. Between them the qualifiers carry the inverse of
  // the last event, so a block that reads them outside a pulse goes wrong.
  task automatic send(input ues_evt_s v);
    ues_evt_s idle;
    begin
      @(posedge clk_i);
      evt_o <= v;
      @(posedge clk_i);
      idle = ues_evt_s'(~v);
      idle.token = 1'b0;
      idle.xact = 1'b0;
      idle.bus_reset = 1'b0;
      idle.sof = 1'b0;
      evt_o <= idle;
    end
  endtask
endmodule
`default_nettype wire

// [test/ues_top_tb.sv]
// Self-checking bench for the endpoint status block over its register bus.
`timescale 1ns/100ps
`default_nettype none
module ues_top_tb;
  import ues_pkg::*;
  logic clk, rst, cyc, stb, we, ack, hs_vld, irq;
  logic [7:0] adr;
  logic [7:0] q;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [6:0] in_len;
  ues_evt_s evt;
  ues_view_s view;
  ues_hs_e hs;
  int fail_count = 0;
  int n_checks = 0;
  logic [2:0] codes [6] = '{ERR_STUFF, ERR_CRC, ERR_EOP, ERR_PID, ERR_MEM,
                            ERR_OTHER};
  ues_top u_ues_top (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .evt_i(evt), .view_o(view), .hs_o(hs), .hs_vld_o(hs_vld),
    .in_len_o(in_len), .irq_o(irq));
  ues_host_model u_ues_host_model (.clk_i(clk), .evt_o(evt));
  always #20 clk = ~clk;
  // ****************************************
  // Bus, event and check tasks
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The request is held until ack is seen at an edge; the wait is bounded.
  task automatic xfer(input logic w, input logic [5:0] idx,
                      input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 1;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: bus answer missing", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic xa(input logic [1:0] ep, input ues_kind_e k, input logic ok,
                    input logic ak, input logic st, input logic [2:0] er,
                    input logic [6:0] rb);
    ues_evt_s e;
    e = '0;
    e.xact = 1'b1;
    e.ep = ep;
    e.kind = k;
    e.ok = ok;
    e.ack = ak;
    e.stall = st;
    e.err = er;
    e.rx_bytes = rb;
    u_ues_host_model.send(e);
    repeat (3) @(posedge clk);
  endtask
  task automatic tok(input logic [1:0] ep, input ues_kind_e k);
    ues_evt_s e;
    e = '0;
    e.token = 1'b1;
    e.ep = ep;
    e.kind = k;
    u_ues_host_model.send(e);
    @(posedge clk);
    chk({7'h00, hs_vld}, 8'h01);
  endtask
  task automatic line(input logic br, input logic sf);
    ues_evt_s e;
    e = '0;
    e.bus_reset = br;
    e.sof = sf;
    u_ues_host_model.send(e);
    repeat (3) @(posedge clk);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h00000000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_CTRL, RST_CTRL);
    rd(IDX_EP0, RST_ZERO);
    rd(IDX_FAULT, RST_ZERO);
    rd(IDX_CNT2TX, RST_ZERO);
    wr(IDX_DEVICE_ADDRESS, 8'hFF);
    chk(view.device_address, 8'h7F);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    wr(IDX_EP0, 8'h77);
    rd(IDX_EP0, 8'h77);
    wr(IDX_EP0, 8'hFF);
    rd(IDX_EP0, 8'hF7);
    wr(IDX_EP1TX, 8'hFF);
    rd(IDX_EP1TX, 8'h0F);
    xa(2'h0, XK_SETUP, 1'b1, 1'b0, 1'b0, ERR_NONE, 7'h00);
    rd(IDX_EP0, 8'hE6);
    line(1'b1, 1'b0);
    rd(IDX_EP0, 8'h80);
    chk(view.ep1tx, 8'h08);
    wr(IDX_EP0, 8'h00);
    rd(IDX_EP0, 8'h00);
    xa(2'h0, XK_SETUP, 1'b1, 1'b0, 1'b0, ERR_NONE, 7'h00);
    rd(IDX_EP0, 8'h00);
    wr(IDX_CTRL, 8'h07);
    wr(IDX_EP0, 8'h33);
    rd(IDX_EP0, 8'h00);
    wr(IDX_EP1TX, 8'h07);
    rd(IDX_EP1TX, 8'h00);
    wr(IDX_CTRL, RST_CTRL);
    for (int s = 0; s < 4; s++) begin
      wr(IDX_EP2RX, s[7:0]);
      tok(2'h2, XK_OUT);
      chk({6'h00, hs}, s[7:0]);
      wr(IDX_EP1TX, s[7:0]);
      tok(2'h1, XK_IN);
      chk({6'h00, hs}, s[7:0]);
    end
    wr(IDX_EP2RX, 8'h03);
    wr(IDX_CNT2RX, 8'h40);
    xa(2'h2, XK_OUT, 1'b1, 1'b0, 1'b0, ERR_NONE, 7'h05);
    rd(IDX_EP2RX, 8'h0E);
    rd(IDX_CNT2RX, 8'h3B);
    chk(view.ep2rx, 8'h0E);
    wr(IDX_EP1TX, 8'h03);
    xa(2'h1, XK_IN, 1'b1, 1'b0, 1'b0, ERR_OTHER, 7'h00);
    chk({7'h00, view.ep1tx[2]}, 8'h00);
    xa(2'h1, XK_IN, 1'b1, 1'b1, 1'b0, ERR_NONE, 7'h00);
    rd(IDX_EP1TX, 8'h0E);
    rd(IDX_LASTSR, 8'h61);
    wr(IDX_EP1TX, 8'h03);
    xa(2'h1, XK_IN, 1'b0, 1'b0, 1'b1, ERR_NONE, 7'h00);
    rd(IDX_EP1TX, 8'h01);
    wr(IDX_EP0, 8'h33);
    xa(2'h0, XK_OUT, 1'b0, 1'b0, 1'b1, ERR_NONE, 7'h00);
    rd(IDX_EP0, 8'h11);
    wr(IDX_EP0, 8'h33);
    wr(IDX_CNT0RX, 8'h08);
    xa(2'h0, XK_OUT, 1'b1, 1'b0, 1'b0, ERR_NONE, 7'h03);
    rd(IDX_EP0, 8'hA6);
    rd(IDX_CNT0RX, 8'h05);
    chk(view.ep0, 8'hA6);
    tok(2'h0, XK_SETUP);
    chk({6'h00, hs}, 8'h03);
    wr(IDX_EP2RX, 8'h03);
    xfer(1'b0, IDX_ISTAT, 8'h00, q);
    foreach (codes[i]) begin
      xa(2'h2, XK_OUT, 1'b0, 1'b0, 1'b0, codes[i], 7'h00);
      rd(IDX_FAULT, {5'h00, codes[i]});
      rd(IDX_ISTAT, 8'h10);
      rd(IDX_FAULT, 8'h00);
    end
    wr(IDX_CNT2TX, 8'hA5);
    rd(IDX_CNT2TX, 8'h25);
    tok(2'h2, XK_IN);
    chk({1'b0, in_len}, 8'h25);
    xfer(1'b0, IDX_ISTAT, 8'h00, q);
    wr(IDX_IMASK, 8'h01);
    line(1'b0, 1'b1);
    chk({7'h00, irq}, 8'h01);
    rd(IDX_ISTAT, 8'h01);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    wr(IDX_IMASK, 8'h00);
    line(1'b0, 1'b1);
    chk({7'h00, irq}, 8'h00);
    rd(IDX_ISTAT, 8'h01);
    wr(IDX_IMASK, 8'h02);
    line(1'b1, 1'b0);
    chk({7'h00, irq}, 8'h01);
    rd(IDX_ISTAT, 8'h02);
    close_out();
  end
endmodule
`default_nettype wire
